//--- shared/mio_defines.svh
// Register offsets, reset values and fixed sizes of the macrocell and port block.
`ifndef MIO_DEFINES_SVH
`define MIO_DEFINES_SVH
`define MIO_OFS_DOUT     8'h00
`define MIO_OFS_DIR      8'h04
`define MIO_OFS_CTRL     8'h08
`define MIO_OFS_MASK     8'h0A
`define MIO_OFS_CELL     8'h0C
`define MIO_OFS_INCELL   8'h10
`define MIO_OFS_PIN      8'h14
`define MIO_RST_BYTE     8'h00
`define MIO_NTERMS       56
`define MIO_LOW_TERMS    24
`define MIO_LOW_NATIVE   3
`define MIO_HIGH_NATIVE  4
`define MIO_BORROW_MAX6  3'h6
`define MIO_BORROW_MAX5  3'h5
`define MIO_NO_OWNER     5'h1F
`define MIO_NCELLS       16
`define MIO_NPINS        27
`define MIO_NIN          24
`define MIO_C_INCELLS    8'h9C
`endif

//--- shared/mio_pkg.sv
// Types shared by the macrocell and port block.
package mio_pkg;
   typedef enum logic [2:0] {
      MIO_SRC_DOUT = 3'h0,
      MIO_SRC_CELL_LOW = 3'h1,
      MIO_SRC_CELL_HIGH = 3'h2,
      MIO_SRC_CS = 3'h3
   } mio_src_e;
   typedef enum logic [1:0] {
      MIO_IN_PASS = 2'h0,
      MIO_IN_LATCH = 2'h1,
      MIO_IN_REG = 2'h2
   } mio_in_e;
   typedef struct packed {
      logic       sel;
      logic       wr;
      logic       rd;
      logic       ale;
      logic [7:0] addr;
      logic [7:0] data;
   } mio_bus_s;
   typedef struct packed {
      logic preset;
      logic clear;
      logic pt_clk;
   } mio_cell_ctl_s;
   typedef struct packed {
      logic polarity;
      logic use_ff;
      logic pin_clk;
      logic node_only;
   } mio_cell_cfg_s;
endpackage

//--- hw/mio_ports.sv
// Output and input macrocells, port output muxes, drivers and host readback.
//
// Contract
// - Low cells own three native terms, borrow six; high cells four, borrow five/six.
// - A product term owned by one cell cannot be borrowed by another.
// - Oversized equations expand through another cell, adding one cycle delay.
// - Host loads all sixteen output cell flip-flops and reads them back.
// - Host load beats preset, clear and clock of the cell.
// - Edge loading captures at write strobe end; level loading follows while active.
// - One eight-bit load mask per group, reset to zero allowing loads.
// - Mask bit one blocks host writes to that cell.
// - Pin driver enable is enable product term ORed with direction bit.
// - Logic output pin without enable equation drives from power-up.
// - Node-only cell frees its pin yet still feeds back.
// - Twenty input cells: ports A, B and four on C.
// - Input cells latch, register or pass; host can read them.
// - Input enable is product term or address strobe; one term per nibble.
// - Ports A, B, C are eight bits, D three, pins configured individually.
// - Pin output muxes data-out, latched address, cell output or chip select.
// - Readback buffer drives one source per read.
// - Without enable term or logic output, direction bit alone drives enable.
// - Host I/O mode drives data-out; inputs read back through data-in.
// - Ports C and D lack control register, default to host I/O.
// - Logic and special modes are fixed configuration; others change at run time.
// - Direction bit one is output, zero input; reset all inputs.
// - Control bit one on A/B selects address-out, zero host I/O.
// - Preset and clear are active high; pin clock captures on rising edge.
`timescale 1ns/10ps
`include "mio_defines.svh"
module mio_ports (
   // Clock and reset.
   input  wire logic                         CLOCK_I,
   input  wire logic                         RST_B_I,
   // Internal host bus.
   input  wire mio_pkg::mio_bus_s            BUS_I,
   output logic [7:0]                        DATA_O,
   // Logic array terms and controls.
   input  wire logic [55:0]                  TERM_I,
   input  wire mio_pkg::mio_cell_ctl_s [15:0] CELL_CTL_I,
   input  wire logic [26:0]                  OE_PT_I,
   input  wire logic [5:0]                   LE_PT_I,
   input  wire logic [1:0]                   CS_I,
   // Programmed configuration.
   input  wire logic [55:0][4:0]             CFG_OWNER_I,
   input  wire logic [15:0][4:0]             CFG_EXP_I,
   input  wire mio_pkg::mio_cell_cfg_s [15:0] CFG_CELL_I,
   input  wire logic                         CFG_LOAD_EDGE_I,
   input  wire mio_pkg::mio_src_e [26:0]     CFG_PIN_SRC_I,
   input  wire logic [26:0]                  CFG_OE_EQ_I,
   input  wire mio_pkg::mio_in_e [23:0]      CFG_IN_MODE_I,
   input  wire logic [23:0]                  CFG_IN_ALE_I,
   // Pins.
   input  wire logic [26:0]                  PIN_I,
   input  wire logic                         PIN_CLK_I,
   output logic [26:0]                       PIN_O,
   output logic [26:0]                       PIN_OE_O,
   // Feedback to the logic array.
   output logic [15:0]                       FEEDBACK_O,
   output logic [23:0]                       INCELL_O,
   output logic                              ALLOC_ERR_O
);

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   function automatic logic [4:0] native_cell(input int t);
      if (t < `MIO_LOW_TERMS) begin
         native_cell = 5'(t / `MIO_LOW_NATIVE);
      end else begin
         native_cell = 5'(8 + (t - `MIO_LOW_TERMS) / `MIO_HIGH_NATIVE);
      end
   endfunction

   // ****************************************
   // Input synchronisers and bus history
   // ****************************************
   logic [26:0] pin_m, pin_s;
   logic        pclk_m, pclk_s, pclk_q;
   logic        wr_q;
   logic [7:0]  addr_q, data_q, lat_addr;
   logic [26:0] next_pin_m, next_pin_s;
   logic        next_pclk_m, next_pclk_s, next_pclk_q, next_wr_q;
   logic [7:0]  next_addr_q, next_data_q, next_lat_addr;
   logic        pclk_rise;

   always_comb begin
      {next_pin_m, next_pin_s} = {PIN_I, pin_m};
      {next_pclk_m, next_pclk_s, next_pclk_q} = {PIN_CLK_I, pclk_m, pclk_s};
      next_wr_q = BUS_I.wr & BUS_I.sel;
      {next_addr_q, next_data_q} = {BUS_I.addr, BUS_I.data};
      next_lat_addr = BUS_I.ale ? BUS_I.addr : lat_addr;
   end

   always_ff @(posedge CLOCK_I) begin
      if (!RST_B_I) begin
         {pin_m, pin_s, pclk_m, pclk_s, pclk_q, wr_q} <= 58'h000000000000000;
         {addr_q, data_q, lat_addr} <= {3{`MIO_RST_BYTE}};
      end else begin
         {pin_m, pin_s} <= {next_pin_m, next_pin_s};
         {pclk_m, pclk_s, pclk_q, wr_q} <= {next_pclk_m, next_pclk_s, next_pclk_q, next_wr_q};
         {addr_q, data_q, lat_addr} <= {next_addr_q, next_data_q, next_lat_addr};
      end
   end

   assign pclk_rise = pclk_s & ~pclk_q;

   // ****************************************
   // Host registers
   // ****************************************
   logic [3:0][7:0] dout, dir, next_dout, next_dir;
   logic [1:0][7:0] ctrl, mask, next_ctrl, next_mask;
   logic            wr_now;

   assign wr_now = BUS_I.wr & BUS_I.sel;

   always_comb begin
      next_dout = dout;
      next_dir = dir;
      next_ctrl = ctrl;
      next_mask = mask;
      for (int p = 0; p < 4; p++) begin
         if (wr_now && hit(BUS_I.addr, `MIO_OFS_DOUT + 8'(p))) next_dout[p] = BUS_I.data;
         if (wr_now && hit(BUS_I.addr, `MIO_OFS_DIR + 8'(p))) next_dir[p] = BUS_I.data;
      end
      for (int g = 0; g < 2; g++) begin
         if (wr_now && hit(BUS_I.addr, `MIO_OFS_CTRL + 8'(g))) next_ctrl[g] = BUS_I.data;
         if (wr_now && hit(BUS_I.addr, `MIO_OFS_MASK + 8'(g))) next_mask[g] = BUS_I.data;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (!RST_B_I) begin
         {dout, dir, ctrl, mask} <= {12{`MIO_RST_BYTE}};
      end else begin
         {dout, dir, ctrl, mask} <= {next_dout, next_dir, next_ctrl, next_mask};
      end
   end

   // ****************************************
   // Product term allocation and output cells
   // ****************************************
   logic [15:0] sum, cell_ff, cell_out, exp_q, next_cell_ff, next_exp_q;
   logic        next_alloc_err;
   logic [3:0]  borrowed;

   always_comb begin
      sum = 16'h0000;
      next_alloc_err = 1'b0;
      borrowed = 4'h0;
      for (int c = 0; c < `MIO_NCELLS; c++) begin
         borrowed = 4'h0;
         for (int t = 0; t < `MIO_NTERMS; t++) begin
            // One owner field per term keeps a consumed term out of every other cell.
            if (CFG_OWNER_I[t] == 5'(c)) begin
               sum[c] = sum[c] | TERM_I[t];
               if (native_cell(t) != 5'(c)) borrowed = borrowed + 4'h1;
            end
         end
         if (borrowed > {1'b0, (c >= 8 && c < 12) ? `MIO_BORROW_MAX5 : `MIO_BORROW_MAX6}) begin
            next_alloc_err = 1'b1;
         end
         if (CFG_EXP_I[c] < 5'(`MIO_NCELLS)) sum[c] = sum[c] | exp_q[CFG_EXP_I[c][3:0]];
      end
   end

   always_comb begin
      next_cell_ff = cell_ff;
      next_exp_q = 16'h0000;
      for (int c = 0; c < `MIO_NCELLS; c++) begin
         logic d;
         logic hit_lvl;
         logic hit_edge;
         d = sum[c] ^ CFG_CELL_I[c].polarity;
         next_exp_q[c] = d;
         hit_lvl = ~CFG_LOAD_EDGE_I & wr_now & hit(BUS_I.addr, `MIO_OFS_CELL + 8'(c / 8));
         hit_edge = CFG_LOAD_EDGE_I & wr_q & ~wr_now & hit(addr_q, `MIO_OFS_CELL + 8'(c / 8));
         if ((hit_lvl || hit_edge) && !mask[c / 8][c % 8]) begin
            next_cell_ff[c] = hit_lvl ? BUS_I.data[c % 8] : data_q[c % 8];
         end else if (CELL_CTL_I[c].preset) begin
            next_cell_ff[c] = 1'b1;
         end else if (CELL_CTL_I[c].clear) begin
            next_cell_ff[c] = 1'b0;
         end else if (CFG_CELL_I[c].pin_clk ? pclk_rise : CELL_CTL_I[c].pt_clk) begin
            next_cell_ff[c] = d;
         end
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (!RST_B_I) begin
         {cell_ff, exp_q, ALLOC_ERR_O} <= 33'h000000000;
      end else begin
         {cell_ff, exp_q, ALLOC_ERR_O} <= {next_cell_ff, next_exp_q, next_alloc_err};
      end
   end

   generate
      for (genvar c = 0; c < `MIO_NCELLS; c++) begin : g_cell
         assign cell_out[c] = CFG_CELL_I[c].use_ff ? cell_ff[c] : exp_q[c];
      end
   endgenerate

   // ****************************************
   // Input cells
   // ****************************************
   logic [23:0] incell, next_incell, en_q, next_en_q, en;
   localparam logic [7:0] c_cells = `MIO_C_INCELLS;

   generate
      for (genvar i = 0; i < `MIO_NIN; i++) begin : g_in
         assign en[i] = CFG_IN_ALE_I[i] ? BUS_I.ale : LE_PT_I[(i / 8) * 2 + (i % 8) / 4];
      end
   endgenerate

   always_comb begin
      next_incell = incell;
      next_en_q = en;
      for (int i = 0; i < `MIO_NIN; i++) begin
         // Port C only carries cells on a few bits; the rest stay zero.
         if (i < 16 || c_cells[i % 8]) begin
            unique case (CFG_IN_MODE_I[i])
               mio_pkg::MIO_IN_LATCH: if (en[i]) next_incell[i] = pin_s[i];
               mio_pkg::MIO_IN_REG:   if (en[i] && !en_q[i]) next_incell[i] = pin_s[i];
               default:               next_incell[i] = pin_s[i];
            endcase
         end else begin
            next_incell[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (!RST_B_I) begin
         {incell, en_q} <= 48'h000000000000;
      end else begin
         {incell, en_q} <= {next_incell, next_en_q};
      end
   end

   // ****************************************
   // Pin output muxes, drivers, readback
   // ****************************************
   logic [26:0] next_pin_o, next_pin_oe;
   logic [7:0]  next_data;
   logic [31:0] pin_pad;

   // Port D has three pins only; padding keeps its readback slice inside the vector.
   assign pin_pad = {5'h00, pin_s};

   always_comb begin
      for (int p = 0; p < `MIO_NPINS; p++) begin
         logic logic_out;
         logic_out = 1'b0;
         next_pin_o[p] = dout[p / 8][p % 8];
         unique case (CFG_PIN_SRC_I[p])
            mio_pkg::MIO_SRC_CELL_LOW: if (!CFG_CELL_I[p % 8].node_only) begin
               next_pin_o[p] = cell_out[p % 8];
               logic_out = 1'b1;
            end
            mio_pkg::MIO_SRC_CELL_HIGH: if (!CFG_CELL_I[8 + p % 8].node_only) begin
               next_pin_o[p] = cell_out[8 + p % 8];
               logic_out = 1'b1;
            end
            mio_pkg::MIO_SRC_CS: begin
               next_pin_o[p] = CS_I[p % 2];
               logic_out = 1'b1;
            end
            default: if (p < 16 && ctrl[p / 8][p % 8]) next_pin_o[p] = lat_addr[p % 8];
         endcase
         // A logic output with no enable equation drives as soon as reset releases.
         next_pin_oe[p] = (CFG_OE_EQ_I[p] & OE_PT_I[p]) | dir[p / 8][p % 8]
                          | (logic_out & ~CFG_OE_EQ_I[p]);
      end
      next_data = DATA_O;
      if (BUS_I.rd && BUS_I.sel) begin
         next_data = `MIO_RST_BYTE;
         for (int p = 0; p < 4; p++) begin
            if (hit(BUS_I.addr, `MIO_OFS_DOUT + 8'(p))) next_data = dout[p];
            if (hit(BUS_I.addr, `MIO_OFS_DIR + 8'(p))) next_data = dir[p];
            if (hit(BUS_I.addr, `MIO_OFS_PIN + 8'(p))) next_data = pin_pad[p * 8 +: 8];
         end
         for (int g = 0; g < 2; g++) begin
            if (hit(BUS_I.addr, `MIO_OFS_CTRL + 8'(g))) next_data = ctrl[g];
            if (hit(BUS_I.addr, `MIO_OFS_MASK + 8'(g))) next_data = mask[g];
            if (hit(BUS_I.addr, `MIO_OFS_CELL + 8'(g))) next_data = cell_ff[g * 8 +: 8];
         end
         for (int g = 0; g < 3; g++) begin
            if (hit(BUS_I.addr, `MIO_OFS_INCELL + 8'(g))) next_data = incell[g * 8 +: 8];
         end
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (!RST_B_I) begin
         {PIN_O, PIN_OE_O, FEEDBACK_O, INCELL_O} <= 94'h000000000000000000000000;
         DATA_O <= `MIO_RST_BYTE;
      end else begin
         {PIN_O, PIN_OE_O, DATA_O} <= {next_pin_o, next_pin_oe, next_data};
         {FEEDBACK_O, INCELL_O} <= {cell_out, incell};
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RST_B_I);

   mask_reset_a: assert property ($rose(RST_B_I) |-> mask == 16'h0000)
      else $error("load mask not zero after reset");
   mask_block_a: assert property (wr_now && !CFG_LOAD_EDGE_I && hit(BUS_I.addr, `MIO_OFS_CELL) && mask[0][0]
      && !CELL_CTL_I[0].preset && !CELL_CTL_I[0].clear && !CELL_CTL_I[0].pt_clk && !CFG_CELL_I[0].pin_clk
      |=> $stable(cell_ff[0]))
      else $error("masked cell was loaded");
   load_prio_a: assert property (wr_now && !CFG_LOAD_EDGE_I && hit(BUS_I.addr, `MIO_OFS_CELL) && !mask[0][0]
      |=> cell_ff[0] == $past(BUS_I.data[0]))
      else $error("host load lost to internal logic");
   edge_load_a: assert property (CFG_LOAD_EDGE_I && wr_q && !wr_now && hit(addr_q, `MIO_OFS_CELL)
      && !mask[0][3] |=> cell_ff[3] == $past(data_q[3]))
      else $error("edge load missed trailing strobe");
   preset_a: assert property (CELL_CTL_I[2].preset && !wr_now && !(wr_q && CFG_LOAD_EDGE_I) |=> cell_ff[2])
      else $error("preset did not set cell");
   oe_dir_a: assert property (dir[0][5] |=> PIN_OE_O[5])
      else $error("direction bit did not enable driver");
   dout_drive_a: assert property (CFG_PIN_SRC_I[20] == mio_pkg::MIO_SRC_DOUT |=> PIN_O[20] == $past(dout[2][4]))
      else $error("host mode pin not driven from data out");
   incell_pass_a: assert property (CFG_IN_MODE_I[3] == mio_pkg::MIO_IN_PASS |=> incell[3] == $past(pin_s[3]))
      else $error("pass input cell did not follow pin");
   addr_out_a: assert property (CFG_PIN_SRC_I[1] == mio_pkg::MIO_SRC_DOUT && ctrl[0][1]
      |=> PIN_O[1] == $past(lat_addr[1]))
      else $error("address out not selected");

endmodule

//--- tb/mio_pin_world.sv
// Far-side pin model: resolves each port pin from the block's driver and the outside world.
`timescale 1ns/10ps
module mio_pin_world (
   // Block side.
   input  wire logic [26:0] drv_i,
   input  wire logic [26:0] pin_oe_i,
   // Outside world.
   input  wire logic [26:0] ext_i,
   // Resolved level.
   output logic [26:0]      level_o
);
   // ***************************************************************
   // Pin resolution
   // ***************************************************************
   // The outside world drives every pin, so no level is left floating.
   // Where the block enables its driver it wins, as a strong push-pull output would.
   always_comb begin
      for (int p = 0; p < 27; p++) begin
         level_o[p] = pin_oe_i[p] ? drv_i[p] : ext_i[p];
      end
   end
endmodule

//--- tb/complex_logic_array_macrocells_and_io_ports_tb_top.sv
// Self-checking testbench of the macrocell and port block.
`timescale 1ns/10ps
`include "mio_defines.svh"
module complex_logic_array_macrocells_and_io_ports_tb_top;
   logic                       clk;
   logic                       rst_b;
   mio_pkg::mio_bus_s          bus;
   logic [55:0]                term;
   mio_pkg::mio_cell_ctl_s [15:0] cell_ctl;
   logic [26:0]                oe_pt;
   logic [5:0]                 le_pt;
   logic [1:0]                 cs;
   logic [55:0][4:0]           owner;
   logic [15:0][4:0]           exp_src;
   mio_pkg::mio_cell_cfg_s [15:0] cell_cfg;
   logic                       edge_mode;
   mio_pkg::mio_src_e [26:0]   pin_src;
   logic [26:0]                oe_eq;
   mio_pkg::mio_in_e [23:0]    in_mode;
   logic [23:0]                in_ale;
   logic [26:0]                ext;
   logic [26:0]                pin_lvl;
   logic                       pin_clk;
   logic [7:0]                 data_o;
   logic [26:0]                pin_o;
   logic [26:0]                pin_oe;
   logic [15:0]                fb;
   logic [23:0]                incell;
   logic                       alloc_err;
   int                         fail_count;
   int                         samples_checked;
   logic                       seen;

   mio_ports dut_u (
      .CLOCK_I(clk), .RST_B_I(rst_b), .BUS_I(bus), .DATA_O(data_o),
      .TERM_I(term), .CELL_CTL_I(cell_ctl), .OE_PT_I(oe_pt), .LE_PT_I(le_pt), .CS_I(cs),
      .CFG_OWNER_I(owner), .CFG_EXP_I(exp_src), .CFG_CELL_I(cell_cfg), .CFG_LOAD_EDGE_I(edge_mode),
      .CFG_PIN_SRC_I(pin_src), .CFG_OE_EQ_I(oe_eq), .CFG_IN_MODE_I(in_mode), .CFG_IN_ALE_I(in_ale),
      .PIN_I(pin_lvl), .PIN_CLK_I(pin_clk), .PIN_O(pin_o), .PIN_OE_O(pin_oe),
      .FEEDBACK_O(fb), .INCELL_O(incell), .ALLOC_ERR_O(alloc_err)
   );

   mio_pin_world world_u (.drv_i(pin_o), .pin_oe_i(pin_oe), .ext_i(ext), .level_o(pin_lvl));

   // ***************************************************************
   // Clock and helpers
   // ***************************************************************
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      samples_checked++;
      if (got !== want) begin
         fail_count++;
         $display("BAD t=%0t seen=%h expected=%h", $time, got, want);
      end
   endtask

   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic ended(input string name);
      $display("Test %s finished at %0t", name, $time);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // One strobed cycle on the host bus, then the bus goes idle.
   task automatic bus_op(input logic w, input logic r, input logic a, input logic [7:0] ad, input logic [7:0] d);
      @(posedge clk);
      bus <= '{sel: ~a, wr: w, rd: r, ale: a, addr: ad, data: d};
      @(posedge clk);
      bus <= '0;
   endtask

   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      bus_op(1'b1, 1'b0, 1'b0, ad, d);
   endtask

   // Read data is registered and stands until the next read, so it is looked at one edge later.
   task automatic rd(input logic [7:0] ad, input logic [7:0] want);
      bus_op(1'b0, 1'b1, 1'b0, ad, 8'h00);
      @(posedge clk);
      chk(data_o, want);
   endtask

   // ***************************************************************
   // Test sequence
   // ***************************************************************
   initial begin
      rst_b = 1'b0;
      bus = '0;
      term = '0;
      cell_ctl = '0;
      oe_pt = '0;
      le_pt = '0;
      cs = '0;
      owner = {56{5'h1F}};
      exp_src = {16{5'h1F}};
      cell_cfg = {16{4'h4}};
      edge_mode = 1'b0;
      oe_eq = 27'h00000FF;
      in_ale = 24'h000F00;
      ext = '0;
      pin_clk = 1'b0;
      fail_count = 0;
      samples_checked = 0;
      for (int p = 0; p < 27; p++) pin_src[p] = mio_pkg::MIO_SRC_DOUT;
      for (int p = 0; p < 24; p++) in_mode[p] = mio_pkg::MIO_IN_PASS;
      for (int p = 8; p < 12; p++) in_mode[p] = mio_pkg::MIO_IN_LATCH;
      for (int p = 12; p < 16; p++) in_mode[p] = mio_pkg::MIO_IN_REG;
      pin_src[18] = mio_pkg::MIO_SRC_CELL_HIGH;
      cyc(3);
      rst_b <= 1'b1;
      cyc(3);
      #1 chk(pin_oe, 27'h0040000);
      rd(`MIO_OFS_MASK, 8'h00);
      rd(`MIO_OFS_MASK + 8'h01, 8'h00);
      rd(`MIO_OFS_DIR, 8'h00);
      ended("reset");

      wr(`MIO_OFS_MASK, 8'h0F);
      rd(`MIO_OFS_MASK, 8'h0F);
      wr(`MIO_OFS_CELL, 8'hFF);
      rd(`MIO_OFS_CELL, 8'hF0);
      wr(`MIO_OFS_MASK, 8'h00);
      wr(`MIO_OFS_CELL, 8'h05);
      rd(`MIO_OFS_CELL, 8'h05);
      edge_mode <= 1'b1;
      wr(`MIO_OFS_CELL, 8'hA5);
      cyc(2);
      rd(`MIO_OFS_CELL, 8'hA5);
      edge_mode <= 1'b0;
      // A held clear must lose to the host load for at least the load cycle.
      cell_ctl[9].clear <= 1'b1;
      wr(`MIO_OFS_CELL + 8'h01, 8'h02);
      seen = 1'b0;
      for (int i = 0; i < 5; i++) begin
         #1 seen = seen | (fb[9] === 1'b1);
         @(posedge clk);
      end
      chk(seen, 1'b1);
      ended("cells");

      wr(`MIO_OFS_DOUT, 8'h5A);
      wr(`MIO_OFS_DIR, 8'hFF);
      bus_op(1'b0, 1'b0, 1'b1, 8'h3C, 8'h00);
      wr(`MIO_OFS_CTRL, 8'h0F);
      cyc(3);
      chk(pin_o[7:0], 8'h5C);
      chk(pin_oe[7:0], 8'hFF);
      rd(`MIO_OFS_CTRL, 8'h0F);
      rd(`MIO_OFS_DIR, 8'hFF);
      wr(`MIO_OFS_CTRL, 8'h00);
      cyc(3);
      chk(pin_o[7:0], 8'h5A);
      wr(`MIO_OFS_DIR, 8'h0F);
      oe_pt <= 27'h0000110;
      cyc(3);
      chk(pin_oe[15:0], 16'h001F);
      oe_pt <= '0;
      ended("pins");

      ext[15:8] <= 8'h33;
      cyc(4);
      bus_op(1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
      ext[15:8] <= 8'hCC;
      cyc(4);
      rd(`MIO_OFS_INCELL + 8'h01, 8'h03);
      rd(`MIO_OFS_PIN + 8'h01, 8'hCC);
      @(posedge clk);
      le_pt[3] <= 1'b1;
      @(posedge clk);
      le_pt[3] <= 1'b0;
      cyc(4);
      rd(`MIO_OFS_INCELL + 8'h01, 8'hC3);
      chk(incell[15:8], 8'hC3);
      ext[23:16] <= 8'hFF;
      cyc(4);
      // Pin C2 reads low: the block drives it from its own high cell.
      rd(`MIO_OFS_INCELL + 8'h02, 8'h98);
      wr(8'h30, 8'hFF);
      rd(8'h30, 8'h00);
      ended("inputs");

      // Cell outputs on pins, node-only feedback, expansion, chip select, preset and both clocks.
      wr(`MIO_OFS_CELL, 8'h00);
      wr(`MIO_OFS_DOUT + 8'h02, 8'h10);
      owner[0] <= 5'h00;
      term[0] <= 1'b1;
      cell_cfg[0] <= 4'h0;
      cell_cfg[2] <= 4'h9;
      cell_cfg[3] <= 4'hE;
      cell_cfg[4] <= 4'hC;
      cell_cfg[5] <= 4'h0;
      exp_src[5] <= 5'h00;
      pin_src[0] <= mio_pkg::MIO_SRC_CELL_LOW;
      pin_src[2] <= mio_pkg::MIO_SRC_CELL_LOW;
      pin_src[24] <= mio_pkg::MIO_SRC_CS;
      cs <= 2'b01;
      cell_ctl[2].preset <= 1'b1;
      cell_ctl[4].pt_clk <= 1'b1;
      pin_clk <= 1'b1;
      @(posedge clk);
      cell_ctl[2].preset <= 1'b0;
      cell_ctl[4].pt_clk <= 1'b0;
      cyc(4);
      #1 chk(pin_o[2:0], 3'h3);
      chk(fb[2], 1'b1);
      chk(fb[5], 1'b1);
      chk(pin_o[20], 1'b1);
      chk(pin_o[24], 1'b1);
      chk(pin_oe[24], 1'b1);
      rd(`MIO_OFS_CELL, 8'h1C);
      ended("logic");

      // Borrowing by a low-half high cell is allowed up to five terms only.
      for (int k = 0; k < 6; k++) begin
         @(posedge clk);
         owner[k] <= 5'h08;
         cyc(3);
         #1 chk(alloc_err, (k == 5) ? 1'b1 : 1'b0);
      end
      ended("alloc");
      test_done();
   end

   // A stuck handshake would otherwise hold the run forever.
   initial begin
      #20000;
      fail_count++;
      test_done();
   end
endmodule
